// >>> hw/iar_pkg.sv
// Package of constants and types for the I2C alias remap block
package iar_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TARGET_5 = 8'h62;
  localparam logic [7:0] OFS_TARGET_6 = 8'h63;
  localparam logic [7:0] OFS_TARGET_7 = 8'h64;
  localparam logic [7:0] OFS_ALIAS_0  = 8'h65;
  localparam logic [7:0] OFS_ALIAS_1  = 8'h66;
  localparam logic [7:0] OFS_FIRST    = OFS_TARGET_5;
  localparam logic [7:0] OFS_LAST     = OFS_ALIAS_1;
  // ----------------------------------------------------------------
  // Slot indices, field layout, reset values
  // ----------------------------------------------------------------
  localparam int         NUM_SLOTS    = 5;
  localparam logic [2:0] IDX_TARGET_5 = 3'h0;
  localparam logic [2:0] IDX_ALIAS_0  = 3'h3;
  localparam logic [2:0] IDX_ALIAS_1  = 3'h4;
  localparam int         ADDR_MSB     = 7;
  localparam int         ADDR_LSB     = 1;
  localparam int         AUTO_ACK_BIT = 0;
  localparam logic [7:0] SLOT_RESET   = 8'h00;
  localparam logic [6:0] ALIAS_OFF    = 7'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  localparam int         NUM_LO_TARGETS = 2;
  localparam int         NUM_HI_TARGETS = 3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE     = 1'b0,
    ST_WAIT_ACK = 1'b1
  } iar_state_t;
endpackage

// >>> hw/iar_slot_regs.sv
// Per-port storage of target and alias slots with registered read port
`timescale 1ns/1ps
module iar_slot_regs #(
  parameter int NUM_PORTS = 4,
  parameter int PORT_W    = 2
) (
  input  wire logic                                   clock,
  input  wire logic                                   rst_n,
  input  wire logic                                   wrEn,
  input  wire logic [PORT_W-1:0]                      wrPort,
  input  wire logic [2:0]                             wrIdx,
  input  wire logic [7:0]                             wrData,
  input  wire logic                                   rdEn,
  input  wire logic [PORT_W-1:0]                      rdPort,
  input  wire logic [2:0]                             rdIdx,
  output logic      [7:0]                             rdData,
  output logic      [NUM_PORTS-1:0][iar_pkg::NUM_SLOTS-1:0][7:0] slots
);
  import iar_pkg::*;

  if (NUM_PORTS < 1 || NUM_PORTS > (1 << PORT_W))
    $error("NUM_PORTS does not fit PORT_W");

  logic [7:0] rdData_reg;

  // ----------------------------------------------------------------
  // Storage, one copy per receive port
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      logic [7:0] slot_reg;
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          slot_reg <= SLOT_RESET;
        end else if (wrEn && wrPort == PORT_W'(p) && wrIdx == 3'(s)) begin
          slot_reg <= wrData;
        end
      end
      assign slots[p][s] = slot_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData_reg <= SLOT_RESET;
    end else if (rdEn) begin
      rdData_reg <= slots[rdPort][rdIdx];
    end
  end
  assign rdData = rdData_reg;

endmodule // iar_slot_regs

// >>> hw/iar_remap.sv
// Alias match and address remap for remote I2C targets, per receive port
// ----------------------------------------------------------------
// Notes on behaviour
// - Every receive port has its own slot registers and the port select chooses which copy a register access reaches.
// - A request whose address equals alias slot n is forwarded to the remote side with target address n substituted.
// - Bits 7:1 of an alias slot are the 7-bit value compared against incoming I2C addresses.
// - An alias slot holding zero never matches, so its remote target is unreachable.
// - Bit 0 of an alias slot set to 1 makes the block acknowledge every write to that target itself.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module iar_remap #(
  parameter int NUM_PORTS = 4,
  parameter int PORT_W    = 2
) (
  input  wire logic                                   clock,
  input  wire logic                                   rst_n,
  input  wire logic [PORT_W-1:0]                      regPortSel,
  input  wire logic [7:0]                             regAddr,
  input  wire logic                                   regWrEn,
  input  wire logic [7:0]                             regWrData,
  input  wire logic                                   regRdEn,
  output logic      [7:0]                             regRdData,
  output logic                                        regRdValid,
  input  wire logic [NUM_PORTS-1:0][iar_pkg::NUM_LO_TARGETS-1:0][6:0] loTargetAddr,
  output logic      [NUM_PORTS-1:0][iar_pkg::NUM_HI_TARGETS-1:0][6:0] hiTargetAddr,
  input  wire logic                                   reqValid,
  output logic                                        reqReady,
  input  wire logic [PORT_W-1:0]                      reqPort,
  input  wire logic [6:0]                             reqAddr,
  input  wire logic                                   reqWrite,
  output logic                                        fwdValid,
  output logic      [6:0]                             fwdAddr,
  output logic      [PORT_W-1:0]                      fwdPort,
  output logic                                        fwdWrite,
  output logic                                        missValid,
  input  wire logic                                   remAckValid,
  input  wire logic                                   remAck,
  output logic                                        ackValid,
  output logic                                        ackOut
);
  import iar_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PORTS < 1 || NUM_PORTS > (1 << PORT_W))
    $error("NUM_PORTS does not fit PORT_W");

  logic [NUM_PORTS-1:0][NUM_SLOTS-1:0][7:0] slots;
  logic [7:0]          slotRdData;
  logic                inRange;
  logic [2:0]          slotIdx;
  logic                isTarget;
  logic [7:0]          wrValue;
  logic                rdHit_reg;
  logic                rdValid_reg;
  logic [6:0]          alias0;
  logic [6:0]          alias1;
  logic                hit0;
  logic                hit1;
  logic                hit;
  logic [6:0]          physAddr;
  logic                autoEn;
  logic                take;
  logic                autoAckNow;
  iar_state_t          state_reg;
  iar_state_t          state_next;
  logic                fwdValid_reg;
  logic [6:0]          fwdAddr_reg;
  logic [PORT_W-1:0]   fwdPort_reg;
  logic                fwdWrite_reg;
  logic                missValid_reg;
  logic                ackValid_reg;
  logic                ackOut_reg;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  assign inRange  = regAddr >= OFS_FIRST && regAddr <= OFS_LAST;
  assign slotIdx  = 3'(regAddr - OFS_FIRST);
  assign isTarget = slotIdx < IDX_ALIAS_0;
  // Reserved bit of a target slot is never stored, so it reads zero
  assign wrValue  = isTarget ? {regWrData[ADDR_MSB:ADDR_LSB], 1'b0} : regWrData;

  iar_slot_regs #(
    .NUM_PORTS (NUM_PORTS),
    .PORT_W    (PORT_W)
  ) u_slots (
    .clock  (clock),
    .rst_n  (rst_n),
    .wrEn   (regWrEn && inRange),
    .wrPort (regPortSel),
    .wrIdx  (slotIdx),
    .wrData (wrValue),
    .rdEn   (regRdEn && inRange),
    .rdPort (regPortSel),
    .rdIdx  (slotIdx),
    .rdData (slotRdData),
    .slots  (slots)
  );

  // Read data come from the store's register; unmapped reads answer zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdHit_reg   <= 1'b0;
      rdValid_reg <= 1'b0;
    end else begin
      rdHit_reg   <= regRdEn && inRange;
      rdValid_reg <= regRdEn;
    end
  end
  assign regRdData  = rdHit_reg ? slotRdData : RD_UNMAPPED;
  assign regRdValid = rdValid_reg;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_hi
    for (genvar t = 0; t < NUM_HI_TARGETS; t++) begin : g_t
      assign hiTargetAddr[p][t] = slots[p][IDX_TARGET_5 + 3'(t)][ADDR_MSB:ADDR_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Alias match and remap
  // ----------------------------------------------------------------
  assign alias0   = slots[reqPort][IDX_ALIAS_0][ADDR_MSB:ADDR_LSB];
  assign alias1   = slots[reqPort][IDX_ALIAS_1][ADDR_MSB:ADDR_LSB];
  assign hit0     = alias0 != ALIAS_OFF && alias0 == reqAddr;
  assign hit1     = alias1 != ALIAS_OFF && alias1 == reqAddr;
  assign hit      = hit0 || hit1;
  // Slot 0 wins if software programs both slots alike
  assign physAddr = hit0 ? loTargetAddr[reqPort][0] : loTargetAddr[reqPort][1];
  assign autoEn   = hit0 ? slots[reqPort][IDX_ALIAS_0][AUTO_ACK_BIT]
                         : slots[reqPort][IDX_ALIAS_1][AUTO_ACK_BIT];
  assign reqReady = state_reg == ST_IDLE;
  assign take     = reqValid && reqReady;
  assign autoAckNow = take && hit && reqWrite && autoEn;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take && hit && !autoAckNow) begin
          state_next = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (remAckValid) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fwdValid_reg  <= 1'b0;
      fwdAddr_reg   <= 7'h00;
      fwdPort_reg   <= '0;
      fwdWrite_reg  <= 1'b0;
      missValid_reg <= 1'b0;
    end else begin
      fwdValid_reg  <= take && hit;
      missValid_reg <= take && !hit;
      if (take && hit) begin
        fwdAddr_reg  <= physAddr;
        fwdPort_reg  <= reqPort;
        fwdWrite_reg <= reqWrite;
      end
    end
  end

  // Local answer ignores the remote acknowledge for a write when auto-ack is on
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ackValid_reg <= 1'b0;
      ackOut_reg   <= 1'b0;
    end else begin
      ackValid_reg <= autoAckNow || (state_reg == ST_WAIT_ACK && remAckValid);
      ackOut_reg   <= autoAckNow || remAck;
    end
  end

  assign fwdValid  = fwdValid_reg;
  assign fwdAddr   = fwdAddr_reg;
  assign fwdPort   = fwdPort_reg;
  assign fwdWrite  = fwdWrite_reg;
  assign missValid = missValid_reg;
  assign ackValid  = ackValid_reg;
  assign ackOut    = ackOut_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_auto_write;
    reqValid && reqReady && hit && reqWrite && autoEn;
  endsequence
  sequence s_local_ack;
    ackValid && ackOut && fwdValid && fwdWrite && reqReady;
  endsequence

  a_remap_addr: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqReady && hit0 |=> fwdValid && fwdAddr == $past(loTargetAddr[reqPort][0]))
    else $error("remapped address wrong");
  a_alias_compare: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqReady && reqAddr != alias0 && reqAddr != alias1 |=> missValid && !fwdValid)
    else $error("address forwarded without alias match");
  a_zero_nomatch: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqReady && reqAddr == ALIAS_OFF |=> !fwdValid)
    else $error("zero alias matched");
  a_auto_ack: assert property (@(posedge clock) disable iff (!rst_n)
    s_auto_write |=> s_local_ack)
    else $error("auto acknowledge missing");
  a_no_auto_ack: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqReady && hit && !autoEn |=> !ackValid ##0 !reqReady)
    else $error("acknowledge given without auto enable");
  a_port_read: assert property (@(posedge clock) disable iff (!rst_n)
    regRdEn && inRange && !regWrEn |=> regRdValid && regRdData == $past(slots[regPortSel][slotIdx]))
    else $error("read of selected port wrong");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    regRdEn && inRange && isTarget |=> regRdData[0] == 1'b0)
    else $error("reserved bit read nonzero");
  a_reset_clear: assert property (@(posedge clock)
    !rst_n |=> slots == '0 && !fwdValid && !ackValid)
    else $error("slots not cleared by reset");

endmodule // iar_remap

// >>> bench/iar_remote_model.sv
// Remote serializer model that answers the most recent forward with an acknowledge when ackDelay is nonzero
`timescale 1ns/1ps
module iar_remote_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       fwdValid,
  input  wire logic [3:0] ackDelay,
  input  wire logic       ackValue,
  output logic            remAckValid,
  output logic            remAck
);
  logic [3:0] waitCnt_reg;
  // Answer returns ackDelay cycles after the forward; a delay of 0 never gives an answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitCnt_reg <= 4'h0;
      remAckValid <= 1'b0;
      remAck      <= 1'b0;
    end else begin
      remAckValid <= (waitCnt_reg == 4'h1);
      // Value flips outside the answer so a stale level never passes as valid
      remAck      <= (waitCnt_reg == 4'h1) ? ackValue : ~remAck;
      if (fwdValid) waitCnt_reg <= ackDelay;
      else if (waitCnt_reg != 4'h0) waitCnt_reg <= waitCnt_reg - 4'h1;
    end
  end
endmodule // iar_remote_model

// >>> bench/tb_top.sv
// Self-checking testbench for the I2C alias remap block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import iar_pkg::*;
  logic                                  clock, rst_n, regWrEn, regRdEn, regRdValid, reqValid, reqReady;
  logic                                  reqWrite, fwdValid, fwdWrite, missValid, remAckValid, remAck;
  logic                                  ackValid, ackOut, ackValue;
  logic [1:0]                            regPortSel, reqPort, fwdPort;
  logic [7:0]                            regAddr, regWrData, regRdData;
  logic [6:0]                            reqAddr, fwdAddr;
  logic [3:0]                            ackDelay;
  logic [3:0][NUM_LO_TARGETS-1:0][6:0]   loTgt;
  logic [3:0][NUM_HI_TARGETS-1:0][6:0]   hiTgt;
  int                                    n_fail, total_checks, cycles;
  iar_remap #(.NUM_PORTS(4), .PORT_W(2)) DUT (.clock(clock), .rst_n(rst_n), .regPortSel(regPortSel),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .loTargetAddr(loTgt), .hiTargetAddr(hiTgt), .reqValid(reqValid),
    .reqReady(reqReady), .reqPort(reqPort), .reqAddr(reqAddr), .reqWrite(reqWrite), .fwdValid(fwdValid),
    .fwdAddr(fwdAddr), .fwdPort(fwdPort), .fwdWrite(fwdWrite), .missValid(missValid),
    .remAckValid(remAckValid), .remAck(remAck), .ackValid(ackValid), .ackOut(ackOut));
  iar_remote_model remote (.clock(clock), .rst_n(rst_n), .fwdValid(fwdValid), .ackDelay(ackDelay),
    .ackValue(ackValue), .remAckValid(remAckValid), .remAck(remAck));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regPortSel = p; regAddr = a; regWrData = d; regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regPortSel = p; regAddr = a; regRdEn = 1'b1;
    @(negedge clock);
    regRdEn = 1'b0;
    `CHK("regRdValid", 1'b1, regRdValid)
    d = regRdData;
  endtask
  task automatic req(input logic [1:0] p, input logic [6:0] a, input logic w);
    @(negedge clock);
    reqPort = p; reqAddr = a; reqWrite = w; reqValid = 1'b1;
    @(negedge clock);
    reqValid = 1'b0;
  endtask
  task automatic wait_ack(output logic v);
    for (int i = 0; i < 20 && ackValid !== 1'b1; i++) @(negedge clock);
    `CHK("ackValid", 1'b1, ackValid)
    v = ackOut;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    for (int k = 0; k < 6; k++) begin
      rd(2'h1, OFS_FIRST + 8'(k), d);
      `CHK("resetVal", SLOT_RESET, d)
    end
    req(2'h1, 7'h28, 1'b1);
    `CHK("missAfterReset", 1'b1, missValid)
    $display("Test reset done");
  endtask
  task automatic t_regs;
    logic [7:0] d;
    for (int p = 0; p < 4; p++) wr(2'(p), OFS_TARGET_6, 8'hA1 + 8'(2 * p));
    for (int p = 0; p < 4; p++) begin
      rd(2'(p), OFS_TARGET_6, d);
      `CHK("targetCopy", (8'hA1 + 8'(2 * p)) & 8'hFE, d)
      `CHK("hiTarget", 7'((8'hA1 + 8'(2 * p)) >> 1), hiTgt[p][1])
    end
    wr(2'h0, OFS_ALIAS_1, 8'h77);
    rd(2'h0, OFS_ALIAS_1, d);
    `CHK("aliasRw", 8'h77, d)
    wr(2'h0, 8'h61, 8'h5A);
    rd(2'h0, 8'h61, d);
    `CHK("unmapped", RD_UNMAPPED, d)
    $display("Test regs done");
  endtask
  task automatic t_remap;
    logic v;
    loTgt[2][0] = 7'h21;
    loTgt[2][1] = 7'h33;
    wr(2'h2, OFS_ALIAS_0, 8'h50);
    wr(2'h2, OFS_ALIAS_1, 8'h60);
    ackDelay = 4'h4;
    ackValue = 1'b1;
    req(2'h2, 7'h28, 1'b1);
    `CHK("fwdValid", 1'b1, fwdValid)
    `CHK("fwdAddr0", 7'h21, fwdAddr)
    `CHK("fwdPort", 2'h2, fwdPort)
    `CHK("fwdWrite", 1'b1, fwdWrite)
    `CHK("busy", 1'b0, reqReady)
    wait_ack(v);
    `CHK("ackOut", 1'b1, v)
    `CHK("readyAgain", 1'b1, reqReady)
    ackValue = 1'b0;
    req(2'h2, 7'h30, 1'b0);
    `CHK("fwdAddr1", 7'h33, fwdAddr)
    `CHK("fwdRead", 1'b0, fwdWrite)
    wait_ack(v);
    `CHK("nack", 1'b0, v)
    req(2'h3, 7'h28, 1'b1);
    `CHK("otherPort", 1'b1, missValid)
    req(2'h2, 7'h29, 1'b1);
    `CHK("nearMiss", 1'b1, missValid)
    $display("Test remap done");
  endtask
  task automatic t_auto;
    logic v;
    wr(2'h2, OFS_ALIAS_1, 8'h61);
    ackValue = 1'b0;
    req(2'h2, 7'h30, 1'b1);
    `CHK("autoFwd", 1'b1, fwdValid)
    `CHK("autoAck", 2'h3, {ackValid, ackOut})
    `CHK("autoReady", 1'b1, reqReady)
    for (int i = 0; i < 8; i++) begin
      @(negedge clock);
      `CHK("lateAckDropped", 1'b0, ackValid)
    end
    req(2'h2, 7'h30, 1'b0);
    `CHK("readNoAuto", 1'b0, ackValid)
    wait_ack(v);
    `CHK("readRemote", 1'b0, v)
    $display("Test auto done");
  endtask
  task automatic t_zero;
    logic v;
    wr(2'h2, OFS_ALIAS_1, 8'h50);
    req(2'h2, 7'h28, 1'b1);
    `CHK("tieSlot0", 7'h21, fwdAddr)
    wait_ack(v);
    wr(2'h2, OFS_ALIAS_0, 8'h01);
    wr(2'h2, OFS_ALIAS_1, 8'h00);
    req(2'h2, 7'h00, 1'b1);
    `CHK("zeroMiss", 3'h4, {missValid, fwdValid, ackValid})
    $display("Test zero done");
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Ceiling well above the hundred or so cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    n_fail = 0; total_checks = 0; cycles = 0; rst_n = 1'b0;
    regWrEn = 1'b0; regRdEn = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; regPortSel = 2'h0; reqPort = 2'h0;
    regAddr = 8'h00; regWrData = 8'h00; reqAddr = 7'h00; loTgt = '0; ackDelay = 4'h3; ackValue = 1'b1;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_remap();
    t_auto();
    t_zero();
    finish_test();
  end
endmodule // tb_top
